// ===== src/ftpg_defs.svh
// Register map, field positions, reset values and constants of the pattern block
`ifndef FTPG_DEFS_SVH
`define FTPG_DEFS_SVH

// Register byte offsets
`define FTPG_REG_CMD          8'h00
`define FTPG_REG_FILE_SIZE    8'h04
`define FTPG_REG_FIRST_FILE   8'h08
`define FTPG_REG_FILE_COUNT   8'h0c
`define FTPG_REG_CTRL         8'h10
`define FTPG_REG_STATUS       8'h14
`define FTPG_REG_INT_STATUS   8'h18
`define FTPG_REG_INT_MASK     8'h1c
`define FTPG_REG_XFER_LO      8'h20
`define FTPG_REG_XFER_HI      8'h24

// Field positions
`define FTPG_CMD_LSB          0
`define FTPG_CMD_MSB          1
`define FTPG_FILE_SIZE_CODE_MSB        3
`define FTPG_CTRL_PATT_LSB    0
`define FTPG_CTRL_PATT_MSB    2
`define FTPG_CTRL_VERIFY_BIT  3
`define FTPG_STAT_BUSY_BIT    0
`define FTPG_STAT_FAIL_BIT    1
`define FTPG_INT_DONE_BIT     0
`define FTPG_INT_FAIL_BIT     1
`define FTPG_INT_W            2

// Reset values
`define FTPG_RST_FILE_SIZE_CODE        4'h0
`define FTPG_RST_FIRST_FILE   32'h0000_0000
`define FTPG_RST_FILE_COUNT   32'h0000_0001
`define FTPG_RST_CTRL         4'h0
`define FTPG_RST_INT_MASK     2'h0

// Decoded file size in 512-byte units is 2^(code + this shift)
`define FTPG_FILE_SIZE_CODE_BASE_SHIFT 3
// Words of 256 bits in one 512-byte unit, as a shift
`define FTPG_UNIT_WORD_SHIFT  4
// Dwords in one data word
`define FTPG_DW_PER_WORD      8
// Nominal user clock of the block and its FIFOs, in MHz
`define FTPG_USER_CLK_MHZ     275

`endif

// ===== src/ftpg_pkg.sv
// Types shared by the pattern generator and checker
package ftpg_pkg;

   typedef enum logic [1:0] {
      FTPG_CMD_FORMAT   = 2'b00,
      FTPG_CMD_WRITE    = 2'b01,
      FTPG_CMD_READ     = 2'b10,
      FTPG_CMD_SHUTDOWN = 2'b11
   } ftpg_cmd_e;

   typedef enum logic [2:0] {
      FTPG_PATT_ZERO = 3'b000,
      FTPG_PATT_ONE  = 3'b001,
      FTPG_PATT_INC  = 3'b010,
      FTPG_PATT_DEC  = 3'b011,
      FTPG_PATT_LFSR = 3'b100
   } ftpg_patt_e;

   typedef enum logic [1:0] {
      FTPG_ST_IDLE  = 2'b00,
      FTPG_ST_WRITE = 2'b01,
      FTPG_ST_READ  = 2'b10
   } ftpg_state_e;

   typedef logic [31:0] ftpg_dword_t;

endpackage : ftpg_pkg

// ===== src/ftpg_lfsr.sv
// Look-ahead LFSR giving several consecutive 32-bit states per clock
`timescale 1ns/10ps
module ftpg_lfsr #(
   parameter int NWORD = 4
) (
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               ce_in,
   input  wire logic               load_in,
   input  wire logic [31:0]        seed_in,
   input  wire logic               adv_in,
   output logic      [NWORD*32-1:0] words_out
);
   import ftpg_pkg::*;

   logic [31:0] state_r;
   logic [31:0] chain [NWORD+1];

   if (NWORD < 1) $error("ftpg_lfsr: NWORD must be at least 1");

   // One step of x^31 + x^21 + x + 1
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   always_comb begin
      chain[0] = state_r;
      for (int i = 0; i < NWORD; i++) begin
         chain[i+1] = step(chain[i]);
      end
   end

   for (genvar g = 0; g < NWORD; g++) begin : g_word
      assign words_out[g*32 +: 32] = chain[g];
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= 32'h0000_0001;
      end else if (ce_in) begin
         if (load_in) begin
            state_r <= seed_in;
         end else if (adv_in) begin
            state_r <= chain[NWORD];
         end
      end
   end
endmodule // ftpg_lfsr

// ===== src/ftpg_top.sv
// Test pattern generator and checker on the file core data FIFOs
// Operation
// - Write command pushes 256-bit pattern words
// - Read command pops and compares each word
// - Same clock and bus width as core
// - Enable stays high whenever FIFO ready
// - Almost-full drops write enable, pauses output
// - Not-empty raises read enable, consumes word
// - Stop at file count times file size
// - Registers hold all test parameters
// - Selector picks one of five patterns
// - Zero and one patterns are constant
// - Counting patterns: header plus data per unit
// - Four commands; only write/read move data
// - Block runs on the user clock
// - Header from unit address counter, incremented
// - Address starts at first index times size
// - LFSR uses x^31 + x^21 + x + 1
// - Mismatch flag set on compare failure
`timescale 1ns/10ps
`include "ftpg_defs.svh"
module ftpg_top #(
   parameter int DATA_W = 256,
   parameter int CNT_W  = 48
) (
   input  wire logic              CLOCK_IN,
   input  wire logic              RESET_N_IN,
   input  wire logic              CE_IN,
   input  wire logic [7:0]        REG_ADDR_IN,
   input  wire logic [31:0]       REG_WDATA_IN,
   input  wire logic              REG_WR_IN,
   input  wire logic              REG_RD_IN,
   output logic      [31:0]       REG_RDATA_OUT,
   output logic                   IRQ_OUT,
   output logic                   CMD_START_OUT,
   output ftpg_pkg::ftpg_cmd_e    CMD_CODE_OUT,
   input  wire logic              TX_FIFO_ALMOST_FULL_IN,
   output logic                   TX_FIFO_WRITE_EN_OUT,
   output logic      [DATA_W-1:0] TX_FIFO_DATA_OUT,
   input  wire logic              RX_FIFO_EMPTY_IN,
   output logic                   RX_FIFO_READ_EN_OUT,
   input  wire logic [DATA_W-1:0] RX_FIFO_DATA_IN,
   output logic                   PATTERN_MISMATCH_OUT
);
   import ftpg_pkg::*;

   localparam int NDW = `FTPG_DW_PER_WORD;

   // bus width must equal the core's 256-bit data path
   if (DATA_W != NDW * 32) $error("ftpg_top: DATA_W must be 256");
   if (CNT_W < 20 || CNT_W > 64) $error("ftpg_top: CNT_W out of 20..64");

   // Parameter registers
   logic [`FTPG_FILE_SIZE_CODE_MSB:0]    file_size_code_r;
   logic [31:0]                 first_file_r;
   logic [31:0]                 file_count_r;
   logic [3:0]                  ctrl_r;
   logic [`FTPG_INT_W-1:0]      int_stat_r;
   logic [`FTPG_INT_W-1:0]      int_mask_r;
   logic [31:0]                 rdata_r;

   // Transfer state
   ftpg_state_e                 state_r;
   ftpg_cmd_e                   cmd_r;
   logic                        start_r;
   logic [CNT_W-1:0]            cnt_r;
   logic [CNT_W-1:0]            end_r;
   logic [CNT_W-1:0]            addr_r;
   logic [3:0]                  word_idx_r;
   logic [31:0]                 data_cnt_r;
   ftpg_patt_e                  patt_r;
   logic                        verify_r;
   logic                        tx_en_r;
   logic                        rx_en_r;
   logic                        rx_valid_r;
   logic [DATA_W-1:0]           pat_r;
   logic [DATA_W-1:0]           exp_d_r;
   logic                        fail_r;
   logic                        irq_r;

   // Combinational terms
   logic                        cmd_wr;
   logic                        busy;
   logic [63:0]                 sectors;
   logic [63:0]                 end_calc;
   logic [63:0]                 addr_calc;
   logic                        tx_en_nxt;
   logic                        rx_en_nxt;
   logic                        adv;
   logic                        done_evt;
   logic                        fail_evt;
   logic [DATA_W-1:0]           pat_nxt;
   logic [63:0]                 addr_ext;
   logic [4*32-1:0]             lfsr_a;
   logic [4*32-1:0]             lfsr_b;
   logic [31:0]                 inc_dw;

   assign busy   = (state_r != FTPG_ST_IDLE) || start_r;
   assign cmd_wr = REG_WR_IN && (REG_ADDR_IN == `FTPG_REG_CMD) && !busy;

   // end size in words = count x decoded size x words per unit
   // start address = first index x decoded size
   assign sectors   = 64'h1 << (7'(file_size_code_r) + 7'(`FTPG_FILE_SIZE_CODE_BASE_SHIFT));
   assign end_calc  = (64'(file_count_r) * sectors)
                      << `FTPG_UNIT_WORD_SHIFT;
   assign addr_calc = 64'(first_file_r) * sectors;
   assign addr_ext  = 64'(addr_r);

   // write enable every cycle the FIFO has room until end
   assign tx_en_nxt = (state_r == FTPG_ST_WRITE) && !TX_FIFO_ALMOST_FULL_IN
                      && (cnt_r != end_r);
   // read enable every cycle the FIFO has data until end
   assign rx_en_nxt = (state_r == FTPG_ST_READ) && !RX_FIFO_EMPTY_IN
                      && (cnt_r != end_r);
   assign adv       = tx_en_nxt || rx_en_nxt;

   assign done_evt  = ((state_r == FTPG_ST_WRITE) && (cnt_r == end_r))
                      || ((state_r == FTPG_ST_READ) && (cnt_r == end_r)
                          && !rx_en_r && !rx_valid_r);
   // returned word checked against the expected value
   assign fail_evt  = rx_valid_r && verify_r
                      && (RX_FIFO_DATA_IN != exp_d_r);

   // two 128-bit halves with different seeds
   ftpg_lfsr #(
      .NWORD (4)
   ) u_lfsr_a (
      .clk_in    (CLOCK_IN),
      .rst_n_in  (RESET_N_IN),
      .ce_in     (CE_IN),
      .load_in   (start_r),
      .seed_in   ({addr_calc[15:0], ~addr_calc[15:0]}),
      .adv_in    (adv),
      .words_out (lfsr_a)
   );

   ftpg_lfsr #(
      .NWORD (4)
   ) u_lfsr_b (
      .clk_in    (CLOCK_IN),
      .rst_n_in  (RESET_N_IN),
      .ce_in     (CE_IN),
      .load_in   (start_r),
      .seed_in   ({~addr_calc[15:0], addr_calc[15:0]}),
      .adv_in    (adv),
      .words_out (lfsr_b)
   );

   // pattern word for the current position
   always_comb begin
      pat_nxt = '0;
      inc_dw  = 32'h0000_0000;
      for (int k = 0; k < NDW; k++) begin
         inc_dw = data_cnt_r + 32'(k);
         case (patt_r)
            FTPG_PATT_ZERO: pat_nxt[k*32 +: 32] = 32'h0000_0000;
            FTPG_PATT_ONE:  pat_nxt[k*32 +: 32] = 32'hffff_ffff;
            FTPG_PATT_INC:  pat_nxt[k*32 +: 32] = inc_dw;
            FTPG_PATT_DEC:  pat_nxt[k*32 +: 32] = ~inc_dw;
            FTPG_PATT_LFSR: begin
               if (k < 4) begin
                  pat_nxt[k*32 +: 32] = lfsr_a[k*32 +: 32];
               end else begin
                  pat_nxt[k*32 +: 32] = lfsr_b[(k-4)*32 +: 32];
               end
            end
            default:        pat_nxt[k*32 +: 32] = 32'h0000_0000;
         endcase
      end
      // first word of each unit carries the 64-bit header in the INC, DEC and LFSR patterns
      if ((word_idx_r == 4'h0) && (patt_r == FTPG_PATT_INC
          || patt_r == FTPG_PATT_DEC || patt_r == FTPG_PATT_LFSR)) begin
         pat_nxt[63:0] = addr_ext;
      end
   end

   // Parameter registers
   // test parameters held for the block
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         file_size_code_r      <= `FTPG_RST_FILE_SIZE_CODE;
         first_file_r <= `FTPG_RST_FIRST_FILE;
         file_count_r <= `FTPG_RST_FILE_COUNT;
         ctrl_r       <= `FTPG_RST_CTRL;
         int_mask_r   <= `FTPG_RST_INT_MASK;
      end else if (CE_IN && REG_WR_IN) begin
         case (REG_ADDR_IN)
            `FTPG_REG_FILE_SIZE:  file_size_code_r <= REG_WDATA_IN[`FTPG_FILE_SIZE_CODE_MSB:0];
            `FTPG_REG_FIRST_FILE: first_file_r <= REG_WDATA_IN;
            `FTPG_REG_FILE_COUNT: file_count_r <= REG_WDATA_IN;
            `FTPG_REG_CTRL:       ctrl_r <= REG_WDATA_IN[3:0];
            `FTPG_REG_INT_MASK:   int_mask_r <= REG_WDATA_IN[1:0];
            default: begin
            end
         endcase
      end
   end

   // Command register and start pulse towards the core
   // all four commands start the core
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         cmd_r   <= FTPG_CMD_FORMAT;
         start_r <= 1'b0;
      end else if (CE_IN) begin
         start_r <= cmd_wr;
         if (cmd_wr) begin
            cmd_r <= ftpg_cmd_e'(REG_WDATA_IN[`FTPG_CMD_MSB:`FTPG_CMD_LSB]);
         end
      end
   end

   // Transfer state machine
   // only write and read commands move FIFO data
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         state_r  <= FTPG_ST_IDLE;
         end_r    <= '0;
         patt_r   <= FTPG_PATT_ZERO;
         verify_r <= 1'b0;
      end else if (CE_IN) begin
         case (state_r)
            FTPG_ST_IDLE: begin
               if (start_r) begin
                  end_r    <= CNT_W'(end_calc);
                  patt_r   <= ftpg_patt_e'(ctrl_r[2:0]);
                  verify_r <= ctrl_r[`FTPG_CTRL_VERIFY_BIT];
                  if (cmd_r == FTPG_CMD_WRITE) begin
                     state_r <= FTPG_ST_WRITE;
                  end else if (cmd_r == FTPG_CMD_READ) begin
                     state_r <= FTPG_ST_READ;
                  end
               end
            end
            FTPG_ST_WRITE,
            FTPG_ST_READ: begin
               if (done_evt) begin
                  state_r <= FTPG_ST_IDLE;
               end
            end
            default: state_r <= FTPG_ST_IDLE;
         endcase
      end
   end

   // Transfer, unit address and data counters
   // counters cleared at reset
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         cnt_r      <= '0;
         addr_r     <= '0;
         word_idx_r <= 4'h0;
         data_cnt_r <= 32'h0000_0000;
      end else if (CE_IN) begin
         if (start_r) begin
            cnt_r      <= '0;
            // address counter seeded from first file index
            addr_r     <= CNT_W'(addr_calc);
            word_idx_r <= 4'h0;
            data_cnt_r <= 32'h0000_0000;
         end else if (adv) begin
            cnt_r      <= cnt_r + CNT_W'(1);
            word_idx_r <= word_idx_r + 4'h1;
            data_cnt_r <= data_cnt_r + 32'(NDW);
            // next unit address after the last word of a unit
            if (word_idx_r == 4'hf) begin
               addr_r <= addr_r + CNT_W'(1);
            end
         end
      end
   end

   // FIFO enables and data word
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         tx_en_r    <= 1'b0;
         rx_en_r    <= 1'b0;
         rx_valid_r <= 1'b0;
         pat_r      <= '0;
         exp_d_r    <= '0;
      end else if (CE_IN) begin
         // registered write enable with its word
         tx_en_r    <= tx_en_nxt;
         rx_en_r    <= rx_en_nxt;
         rx_valid_r <= rx_en_r;
         exp_d_r    <= pat_r;
         if (adv) begin
            pat_r <= pat_nxt;
         end
      end
   end

   // Mismatch flag, held until the next command start
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         fail_r <= 1'b0;
      end else if (CE_IN) begin
         if (fail_evt) begin
            fail_r <= 1'b1;
         end else if (start_r) begin
            fail_r <= 1'b0;
         end
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         int_stat_r <= '0;
         irq_r      <= 1'b0;
      end else if (CE_IN) begin
         for (int i = 0; i < `FTPG_INT_W; i++) begin
            if ((i == `FTPG_INT_DONE_BIT && done_evt)
                || (i == `FTPG_INT_FAIL_BIT && fail_evt)) begin
               int_stat_r[i] <= 1'b1;
            end else if (REG_WR_IN && REG_WDATA_IN[i]
                         && REG_ADDR_IN == `FTPG_REG_INT_STATUS) begin
               int_stat_r[i] <= 1'b0;
            end
         end
         irq_r <= |(int_stat_r & int_mask_r);
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         rdata_r <= 32'h0000_0000;
      end else if (CE_IN) begin
         rdata_r <= 32'h0000_0000;
         if (REG_RD_IN) begin
            case (REG_ADDR_IN)
               `FTPG_REG_CMD:        rdata_r <= {30'h0, cmd_r};
               `FTPG_REG_FILE_SIZE:  rdata_r <= {28'h0, file_size_code_r};
               `FTPG_REG_FIRST_FILE: rdata_r <= first_file_r;
               `FTPG_REG_FILE_COUNT: rdata_r <= file_count_r;
               `FTPG_REG_CTRL:       rdata_r <= {28'h0, ctrl_r};
               `FTPG_REG_STATUS:     rdata_r <= {30'h0, fail_r, busy};
               `FTPG_REG_INT_STATUS: rdata_r <= {30'h0, int_stat_r};
               `FTPG_REG_INT_MASK:   rdata_r <= {30'h0, int_mask_r};
               `FTPG_REG_XFER_LO:    rdata_r <= cnt_r[31:0];
               `FTPG_REG_XFER_HI:    rdata_r <= 32'(64'(cnt_r) >> 32);
               default:              rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign REG_RDATA_OUT        = rdata_r;
   assign IRQ_OUT              = irq_r;
   assign CMD_START_OUT        = start_r;
   assign CMD_CODE_OUT         = cmd_r;
   assign TX_FIFO_WRITE_EN_OUT = tx_en_r;
   assign TX_FIFO_DATA_OUT     = pat_r;
   assign RX_FIFO_READ_EN_OUT  = rx_en_r;
   assign PATTERN_MISMATCH_OUT = fail_r;

endmodule // ftpg_top

// ===== verification/ftpg_props.sv
// Port-level checker for the pattern generator and checker
`timescale 1ns/10ps
module ftpg_props
   import ftpg_pkg::*;
(
   input wire logic      CLOCK_IN,
   input wire logic      RESET_N_IN,
   input wire logic      CMD_START_OUT,
   input wire ftpg_cmd_e CMD_CODE_OUT,
   input wire logic      TX_FIFO_ALMOST_FULL_IN,
   input wire logic      TX_FIFO_WRITE_EN_OUT,
   input wire logic      RX_FIFO_EMPTY_IN,
   input wire logic      RX_FIFO_READ_EN_OUT,
   input wire logic      PATTERN_MISMATCH_OUT,
   input wire logic      REG_WR_IN
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);

   sequence s_wr_go;
      CMD_START_OUT && CMD_CODE_OUT == FTPG_CMD_WRITE
      ##1 !TX_FIFO_ALMOST_FULL_IN;
   endsequence
   sequence s_rd_go;
      CMD_START_OUT && CMD_CODE_OUT == FTPG_CMD_READ
      ##1 !RX_FIFO_EMPTY_IN;
   endsequence

   AST_WR_START:
      assert property (s_wr_go |=> TX_FIFO_WRITE_EN_OUT)
      else $error("no write enable after write start");
   AST_RD_START:
      assert property (s_rd_go |=> RX_FIFO_READ_EN_OUT)
      else $error("no read enable after read start");
   AST_AF_PAUSE:
      assert property (TX_FIFO_ALMOST_FULL_IN |=> !TX_FIFO_WRITE_EN_OUT)
      else $error("write enable while almost full");
   AST_RD_NEEDS_DATA:
      assert property (RX_FIFO_READ_EN_OUT |-> !$past(RX_FIFO_EMPTY_IN))
      else $error("read enable without data");
   AST_WR_NO_GAP:
      assert property ($fell(TX_FIFO_WRITE_EN_OUT)
         && !$past(TX_FIFO_ALMOST_FULL_IN) |-> !TX_FIFO_WRITE_EN_OUT[*8])
      else $error("write enable gap with room");
   AST_RD_NO_GAP:
      assert property ($fell(RX_FIFO_READ_EN_OUT)
         && !$past(RX_FIFO_EMPTY_IN) |-> !RX_FIFO_READ_EN_OUT[*8])
      else $error("read enable gap with data");
   AST_FIFO_BY_CMD:
      assert property ((!TX_FIFO_WRITE_EN_OUT || CMD_CODE_OUT ==
         FTPG_CMD_WRITE) && (!RX_FIFO_READ_EN_OUT || CMD_CODE_OUT ==
         FTPG_CMD_READ))
      else $error("FIFO enable under wrong command");
   AST_RESET_QUIET:
      assert property ($rose(RESET_N_IN) |-> !(TX_FIFO_WRITE_EN_OUT ||
         RX_FIFO_READ_EN_OUT || PATTERN_MISMATCH_OUT))
      else $error("outputs active after reset");
   AST_MISMATCH_CAUSE:
      assert property ($rose(PATTERN_MISMATCH_OUT)
         |-> $past(RX_FIFO_READ_EN_OUT, 2))
      else $error("mismatch without a compared word");
   AST_MISMATCH_STICKY:
      assert property (PATTERN_MISMATCH_OUT && !REG_WR_IN && !CMD_START_OUT
         |=> PATTERN_MISMATCH_OUT)
      else $error("mismatch flag dropped");
endmodule // ftpg_props

bind ftpg_top ftpg_props ftpg_props_inst (
   .CLOCK_IN, .RESET_N_IN, .CMD_START_OUT, .CMD_CODE_OUT,
   .TX_FIFO_ALMOST_FULL_IN, .TX_FIFO_WRITE_EN_OUT, .RX_FIFO_EMPTY_IN,
   .RX_FIFO_READ_EN_OUT, .PATTERN_MISMATCH_OUT, .REG_WR_IN);

// ===== verification/ftpg_fifo_model.sv
// Far-side model of the transmit and receive data FIFOs
`timescale 1ns/10ps
module ftpg_fifo_model (
   input  wire logic         clk_in,
   input  wire logic         clr_in,
   input  wire logic         slow_in,
   input  wire logic         wr_en_in,
   input  wire logic [255:0] wr_data_in,
   output logic              afull_out,
   input  wire logic         rd_en_in,
   output logic              empty_out,
   output logic      [255:0] rd_data_out
);
   logic [255:0] cap [0:255];
   logic [255:0] src [0:255];
   int           n_wr   = 0;
   int           n_rd   = 0;
   int           n_fill = 0;
   logic [2:0]   tick   = 3'h0;
   initial begin
      afull_out = 1'b0;
      empty_out = 1'b1;
      rd_data_out = '0;
   end
   // full-width words, moved only under enables
   always @(posedge clk_in) begin
      tick <= tick + 3'h1;
      afull_out <= slow_in && tick[2];
      empty_out <= n_rd >= n_fill || (slow_in && tick[1]);
      if (wr_en_in) begin
         cap[n_wr[7:0]] <= wr_data_in;
         n_wr <= n_wr + 1;
      end
      // Popped word stands one cycle, then the bus churns
      rd_data_out <= ~rd_data_out;
      if (rd_en_in) begin
         rd_data_out <= src[n_rd[7:0]];
         n_rd <= n_rd + 1;
      end
      if (clr_in) begin
         n_wr <= 0;
         n_rd <= 0;
      end
   end
endmodule // ftpg_fifo_model

// ===== verification/ftpg_top_test.sv
// Self-checking bench for the pattern generator and checker
`timescale 1ns/10ps
module ftpg_top_test;
   import ftpg_pkg::*;
   logic         clk, rst_n, ce, wr_s, rd_s, slow, clr;
   logic [7:0]   addr;
   logic [31:0]  wdata, rdata;
   logic         irq, start, tx_we, tx_af, rx_re, rx_empty, mism;
   ftpg_cmd_e    code;
   logic [255:0] tx_d, rx_d;
   int           n_fail = 0;
   int           checked = 0;

   ftpg_top ftpg_top_inst (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s),
      .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq),
      .CMD_START_OUT(start), .CMD_CODE_OUT(code),
      .TX_FIFO_ALMOST_FULL_IN(tx_af), .TX_FIFO_WRITE_EN_OUT(tx_we),
      .TX_FIFO_DATA_OUT(tx_d), .RX_FIFO_EMPTY_IN(rx_empty),
      .RX_FIFO_READ_EN_OUT(rx_re), .RX_FIFO_DATA_IN(rx_d),
      .PATTERN_MISMATCH_OUT(mism));
   ftpg_fifo_model ftpg_fifo_model_inst (
      .clk_in(clk), .clr_in(clr), .slow_in(slow), .wr_en_in(tx_we),
      .wr_data_in(tx_d), .afull_out(tx_af), .rd_en_in(rx_re),
      .empty_out(rx_empty), .rd_data_out(rx_d));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic close_out;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [255:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] stp(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected word n of a transfer starting at unit address a
   function automatic logic [255:0] expw(input int p, n,
                                          input logic [31:0] a);
      logic [255:0] w;
      logic [31:0]  sa, sb;
      sa = {a[15:0], ~a[15:0]};
      sb = ~sa;
      for (int i = 0; i < 4 * n; i++) begin
         sa = stp(sa);
         sb = stp(sb);
      end
      for (int i = 0; i < 8; i++) w[32*i +: 32] = 32'(8 * n + i);
      if (p == 3) w = ~w;
      if (p == 4) for (int i = 0; i < 4; i++) begin
         w[32*i +: 32] = sa;
         w[32*i+128 +: 32] = sb;
         sa = stp(sa);
         sb = stp(sb);
      end
      if (p > 1 && n % 16 == 0) w[63:0] = {32'h0, a + 32'(n / 16)};
      if (p == 0 || (p > 4 && p < 8)) w = '0;
      if (p == 1) w = '1;
      return w;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   // File size code 0 gives 8 units; first index 1 starts at unit 8
   // Verify bit is inverted, so p above 7 runs without verify
   task automatic setup(input int p, cnt, input logic [31:0] m);
      clr <= 1'b1;
      ftpg_fifo_model_inst.n_fill <= 0;
      wr(8'h04, 32'h0);
      clr <= 1'b0;
      wr(8'h08, 32'h1);
      wr(8'h0c, 32'(cnt));
      wr(8'h10, 32'(p) ^ 32'h8);
      wr(8'h18, 32'h3);
      wr(8'h1c, m);
   endtask

   task automatic go(input logic [31:0] c);
      logic [31:0] s;
      wr(8'h00, c);
      s = 32'h1;
      for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) rd(8'h14, s);
      chk(s[0], 0);
   endtask

   task automatic t_reset;
      logic [31:0] r;
      chk({irq, start, tx_we, rx_re, mism}, 0);
      for (int i = 1; i < 10; i++) begin
         rd(8'(4 * i), r);
         chk(r, i == 3);
      end
      rd(8'h30, r);
      chk(r, 0);
   endtask

   task automatic t_write(input int p, cnt, input logic s);
      logic [31:0] r;
      slow <= s;
      setup(p, cnt, 32'h0);
      go(32'h1);
      chk(ftpg_fifo_model_inst.n_wr, 128 * cnt);
      for (int n = 0; n < 128 * cnt; n++)
         chk(ftpg_fifo_model_inst.cap[n], expw(p, n, 8));
      rd(8'h20, r);
      chk(r, 128 * cnt);
   endtask

   task automatic t_read(input int p, input logic bad);
      logic [31:0] r;
      slow <= p[0];
      setup(p, 1, bad ? 32'h3 : 32'h0);
      for (int n = 0; n < 128; n++)
         ftpg_fifo_model_inst.src[n] = expw(p, n, 8);
      if (bad)
         ftpg_fifo_model_inst.src[77][200] = ~ftpg_fifo_model_inst.src[77][200];
      ftpg_fifo_model_inst.n_fill <= 128;
      go(32'h2);
      chk(ftpg_fifo_model_inst.n_rd, 128);
      chk(mism, bad && p < 8);
      rd(8'h18, r);
      chk(r, {bad && p < 8, 1'b1});
      chk(irq, bad);
      wr(8'h18, 32'h3);
      rd(8'h18, r);
      chk({irq, r}, 0);
   endtask

   task automatic t_other;
      logic [31:0] r;
      for (int c = 0; c < 4; c += 3) begin
         setup(2, 1, 32'h3);
         wr(8'h00, 32'(c));
         @(posedge clk);
         chk({start, 2'(code)}, {1'b1, 2'(c)});
         repeat (8) @(posedge clk);
         chk({start, mism, tx_we, rx_re}, 0);
         rd(8'h18, r);
         chk({irq, r}, 0);
         chk(ftpg_fifo_model_inst.n_wr + ftpg_fifo_model_inst.n_rd, 0);
      end
   endtask

   // Clock enable freeze, then a reset in mid-transfer
   task automatic t_midreset;
      logic [31:0]  r;
      logic [255:0] w;
      setup(2, 1, 32'h0);
      wr(8'h00, 32'h1);
      repeat (20) @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      w = tx_d;
      repeat (4) @(posedge clk);
      chk(tx_d, w);
      ce <= 1'b1;
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({irq, start, tx_we, rx_re, mism}, 0);
      rd(8'h20, r);
      chk(r, 0);
      rd(8'h14, r);
      chk(r, 0);
   endtask

   initial begin
      #(30000 * 8);
      n_fail++;
      close_out;
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      slow = 1'b0;
      clr = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      for (int p = 0; p < 6; p++) t_write(p, p == 4 ? 2 : 1, p[0]);
      for (int p = 0; p < 5; p++) t_read(p, p == 2);
      t_read(10, 1'b1);
      t_other;
      t_midreset;
      close_out;
   end
endmodule // ftpg_top_test
